// File: secure_region_pkg.sv
package secure_region_pkg;
	// ----------------------------------------------------------------
	// version status register
	// ----------------------------------------------------------------
	localparam logic [31:0] STATUS_ADDR = 32'h0000_0500;
	localparam int LOCK_BIT = 0;
	localparam int THRESH_LSB = 16;
	localparam int THRESH_MSB = 23;
	localparam int VERSION_W = THRESH_MSB - THRESH_LSB + 1;
	localparam logic LOCK_RESET = 1'h0;
	localparam logic [VERSION_W-1:0] THRESH_RESET = 8'h00;

	// ----------------------------------------------------------------
	// management saved-state area: region-interruption flag
	// ----------------------------------------------------------------
	localparam logic [15:0] MGMT_FLAG_OFFSET = 16'h7EE0;
	localparam logic [2:0] MGMT_FLAG_BIT = 3'h1;

	// ----------------------------------------------------------------
	// core execution state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OUTSIDE = 2'b00,
		ST_INSIDE = 2'b01,
		ST_PAUSED = 2'b10,
		ST_WAIT_STARTUP = 2'b11
	} region_state_t;
endpackage

// File: version_status_reg.sv
`timescale 1ns/1ns
// holds the lock bit and the latched threshold; registered read port
module version_status_reg #(
	parameter int VERSION_W = secure_region_pkg::VERSION_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic secure_instr_ok,
	input wire logic [VERSION_W-1:0] fw_threshold,
	input wire logic safer_mode_support,
	input wire logic rd_en,
	input wire logic [31:0] rd_addr,
	output logic [63:0] rd_data,
	output logic rd_ack,
	output logic rd_err,
	output logic lock,
	output logic [VERSION_W-1:0] threshold
);
	typedef struct packed {
		logic lock;
		logic [VERSION_W-1:0] thresh;
		logic [63:0] rdata;
		logic ack;
		logic err;
	} status_state_t;

	status_state_t st_r;
	status_state_t st_nxt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// the lock is one-way until reset, so a second good instruction
	// cannot move the threshold under a running launch check
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.err = 1'b0;
		if (secure_instr_ok && !st_r.lock) begin
			st_nxt.lock = 1'b1;
			st_nxt.thresh = fw_threshold;
		end
		if (rd_en) begin
			st_nxt.ack = 1'b1;
			st_nxt.rdata = 64'h0;
			if (rd_addr == secure_region_pkg::STATUS_ADDR) begin
				st_nxt.rdata[secure_region_pkg::LOCK_BIT] = st_r.lock;
				if (safer_mode_support) begin
					st_nxt.rdata[secure_region_pkg::THRESH_MSB:
						secure_region_pkg::THRESH_LSB] = st_r.thresh;
				end
			end else begin
				st_nxt.err = 1'b1; // unmapped address faults
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r.lock <= secure_region_pkg::LOCK_RESET;
			st_r.thresh <= secure_region_pkg::THRESH_RESET;
			st_r.rdata <= 64'h0;
			st_r.ack <= 1'b0;
			st_r.err <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data = st_r.rdata;
	assign rd_ack = st_r.ack;
	assign rd_err = st_r.err;
	assign lock = st_r.lock;
	assign threshold = st_r.thresh;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	lock_sticky_a: assert property (
		lock |=> lock && $stable(threshold))
		else $error("lock or threshold changed after latching");
	lock_catch_a: assert property (
		secure_instr_ok && !lock |=> lock && threshold == $past(fw_threshold))
		else $error("threshold not latched on first good instruction");
	status_read_a: assert property (
		rd_en && rd_addr == secure_region_pkg::STATUS_ADDR
		|=> rd_ack && rd_data[0] == $past(lock) && rd_data[15:1] == 15'h0
			&& rd_data[63:24] == 40'h0)
		else $error("status read shows wrong lock or reserved bits");
endmodule // version_status_reg

// File: secure_region_exit_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - on management-event exit, set saved-state flag at 07EE0H bit 1.
// - re-init outside virtualization: exit, reset state, firmware or wait.
// - re-init in virtualization root operation is blocked as usual.
// - re-init in non-root: exit then vm exit with region bit set.
// - never inside while waiting; startup messages inside are discarded.
// - after re-init and startups, mode flag 0, page cache state kept.
// - direct memory access to processor-reserved memory is rejected.
// - secure-launch instruction inside the region, unless paused, raises invalid opcode.
// - responding core inside at launch-enter exits then waits startup.
// - responding core inside at launch-exit pauses until it completes.
// - trusted launch leaves region configuration and regions untouched.
// - expected version latched on first good region instruction, kept.
// - signed module launches only if lock is clear or its version meets threshold.
// - version status is a read-only register at address 500h.
// - bit 0 is lock; when clear any signed module launches.
// - bits 23:16 threshold if safer mode, else 0; others zero.
// - every entry and exit flushes translations and clears address watch.
module secure_region_exit_ctrl #(
	parameter int VERSION_W = secure_region_pkg::VERSION_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enter_region,
	input wire logic exit_region,
	input wire logic system_management_event,
	input wire logic reinit_req,
	input wire logic startup_interprocessor_message,
	input wire logic virt_root,
	input wire logic virt_nonroot,
	input wire logic boot_core,
	input wire logic secure_launch_instruction,
	input wire logic launch_enter_leaf,
	input wire logic launch_exit_leaf,
	input wire logic launch_exit_done,
	input wire logic secure_instr_ok,
	input wire logic [VERSION_W-1:0] fw_threshold,
	input wire logic safer_mode_support,
	input wire logic module_launch_req,
	input wire logic [VERSION_W-1:0] module_version,
	input wire logic dma_req,
	input wire logic dma_hits_reserved,
	input wire logic status_rd,
	input wire logic [31:0] status_addr,
	output logic [63:0] status_rdata,
	output logic status_ack,
	output logic status_err,
	output logic in_region,
	output logic async_secure_exit,
	output logic mgmt_flag_wr,
	output logic [15:0] mgmt_flag_offset,
	output logic [2:0] mgmt_flag_bit,
	output logic arch_reset,
	output logic run_firmware,
	output logic wait_startup,
	output logic vm_exit,
	output logic vm_exit_region_bit,
	output logic reinit_blocked,
	output logic startup_discard,
	output logic invalid_opcode_fault,
	output logic core_paused,
	output logic translation_flush,
	output logic watch_clear,
	output logic dma_grant,
	output logic dma_reject,
	output logic launch_allow,
	output logic launch_shutdown
);
	typedef struct packed {
		secure_region_pkg::region_state_t st;
		logic axit;
		logic mgmt_wr;
		logic areset;
		logic fw;
		logic vmex;
		logic blocked;
		logic discard;
		logic opf;
		logic flush;
		logic dgrant;
		logic dreject;
		logic lallow;
		logic lshut;
	} ctrl_state_t;

	ctrl_state_t cs_r;
	ctrl_state_t cs_nxt;
	logic lock;
	logic [VERSION_W-1:0] threshold;

	// ----------------------------------------------------------------
	// version status register
	// ----------------------------------------------------------------
	version_status_reg #(
		.VERSION_W(VERSION_W)
	) status_u (
		.clk(clk),
		.rst(rst),
		.secure_instr_ok(secure_instr_ok),
		.fw_threshold(fw_threshold),
		.safer_mode_support(safer_mode_support),
		.rd_en(status_rd),
		.rd_addr(status_addr),
		.rd_data(status_rdata),
		.rd_ack(status_ack),
		.rd_err(status_err),
		.lock(lock),
		.threshold(threshold)
	);

	// launch gate; unlocked means the version is not consulted at all
	function automatic logic version_ok(input logic lk,
		input logic [VERSION_W-1:0] ver, input logic [VERSION_W-1:0] thr);
		version_ok = !lk || (ver >= thr);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// priority inside the region: re-init, management event,
	// launch-enter, launch-exit, then ordinary exit; only one exit
	// is taken per cycle so the flush is never issued twice
	always_comb begin
		cs_nxt = cs_r;
		cs_nxt.axit = 1'b0;
		cs_nxt.mgmt_wr = 1'b0;
		cs_nxt.areset = 1'b0;
		cs_nxt.fw = 1'b0;
		cs_nxt.vmex = 1'b0;
		cs_nxt.blocked = 1'b0;
		cs_nxt.discard = 1'b0;
		cs_nxt.opf = 1'b0;
		cs_nxt.flush = 1'b0;
		cs_nxt.dgrant = 1'b0;
		cs_nxt.dreject = 1'b0;
		cs_nxt.lallow = 1'b0;
		cs_nxt.lshut = 1'b0;
		// page cache, its map and engine state live elsewhere and are
		// never touched here, by re-init or by a trusted launch
		case (cs_r.st)
			secure_region_pkg::ST_OUTSIDE: begin
				if (enter_region) begin
					cs_nxt.st = secure_region_pkg::ST_INSIDE;
					cs_nxt.flush = 1'b1;
				end
			end
			secure_region_pkg::ST_INSIDE: begin
				if (reinit_req && virt_root) begin
					cs_nxt.blocked = 1'b1;
				end else if (reinit_req && virt_nonroot) begin
					cs_nxt.st = secure_region_pkg::ST_OUTSIDE;
					cs_nxt.axit = 1'b1;
					cs_nxt.vmex = 1'b1;
					cs_nxt.flush = 1'b1;
				end else if (reinit_req) begin
					cs_nxt.axit = 1'b1;
					cs_nxt.areset = 1'b1;
					cs_nxt.flush = 1'b1;
					cs_nxt.fw = boot_core;
					cs_nxt.st = boot_core ? secure_region_pkg::ST_OUTSIDE
						: secure_region_pkg::ST_WAIT_STARTUP;
				end else if (system_management_event) begin
					cs_nxt.st = secure_region_pkg::ST_OUTSIDE;
					cs_nxt.axit = 1'b1;
					cs_nxt.mgmt_wr = 1'b1;
					cs_nxt.flush = 1'b1;
				end else if (launch_enter_leaf) begin
					cs_nxt.st = secure_region_pkg::ST_WAIT_STARTUP;
					cs_nxt.axit = 1'b1;
					cs_nxt.flush = 1'b1;
				end else if (launch_exit_leaf) begin
					cs_nxt.st = secure_region_pkg::ST_PAUSED;
				end else if (exit_region) begin
					cs_nxt.st = secure_region_pkg::ST_OUTSIDE;
					cs_nxt.flush = 1'b1;
				end
				if (secure_launch_instruction) begin
					cs_nxt.opf = 1'b1;
				end
				if (startup_interprocessor_message) begin
					cs_nxt.discard = 1'b1;
				end
			end
			secure_region_pkg::ST_PAUSED: begin
				// region and its configuration stay as they were
				if (launch_exit_done) begin
					cs_nxt.st = secure_region_pkg::ST_INSIDE;
				end
				if (startup_interprocessor_message) begin
					cs_nxt.discard = 1'b1;
				end
			end
			secure_region_pkg::ST_WAIT_STARTUP: begin
				// entry requests are ignored here: no region while waiting
				if (startup_interprocessor_message) begin
					cs_nxt.st = secure_region_pkg::ST_OUTSIDE;
				end
			end
			default: cs_nxt.st = secure_region_pkg::ST_OUTSIDE;
		endcase
		if (dma_req) begin
			cs_nxt.dreject = dma_hits_reserved;
			cs_nxt.dgrant = !dma_hits_reserved;
		end
		if (module_launch_req) begin
			cs_nxt.lallow = version_ok(lock, module_version, threshold);
			cs_nxt.lshut = !version_ok(lock, module_version, threshold);
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_r <= '0;
			cs_r.st <= secure_region_pkg::ST_OUTSIDE;
		end else begin
			cs_r <= cs_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign in_region = (cs_r.st == secure_region_pkg::ST_INSIDE)
		|| (cs_r.st == secure_region_pkg::ST_PAUSED);
	assign core_paused = (cs_r.st == secure_region_pkg::ST_PAUSED);
	assign wait_startup = (cs_r.st == secure_region_pkg::ST_WAIT_STARTUP);
	assign async_secure_exit = cs_r.axit;
	assign mgmt_flag_wr = cs_r.mgmt_wr;
	assign mgmt_flag_offset = secure_region_pkg::MGMT_FLAG_OFFSET;
	assign mgmt_flag_bit = secure_region_pkg::MGMT_FLAG_BIT;
	assign arch_reset = cs_r.areset;
	assign run_firmware = cs_r.fw;
	assign vm_exit = cs_r.vmex;
	assign vm_exit_region_bit = cs_r.vmex;
	assign reinit_blocked = cs_r.blocked;
	assign startup_discard = cs_r.discard;
	assign invalid_opcode_fault = cs_r.opf;
	assign translation_flush = cs_r.flush;
	assign watch_clear = cs_r.flush;
	assign dma_grant = cs_r.dgrant;
	assign dma_reject = cs_r.dreject;
	assign launch_allow = cs_r.lallow;
	assign launch_shutdown = cs_r.lshut;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	mgmt_flag_a: assert property (
		in_region && !core_paused && !reinit_req && system_management_event
		|=> mgmt_flag_wr && async_secure_exit && !in_region)
		else $error("management event exit without saved-state flag");
	root_block_a: assert property (
		in_region && !core_paused && reinit_req && virt_root
		|=> reinit_blocked && in_region && !async_secure_exit)
		else $error("re-init not blocked in root operation");
	nonroot_exit_a: assert property (
		in_region && !core_paused && reinit_req && !virt_root && virt_nonroot
		|=> vm_exit && vm_exit_region_bit && async_secure_exit)
		else $error("non-root re-init lacks vm exit");
	wait_outside_a: assert property (
		wait_startup && !startup_interprocessor_message
		|=> wait_startup && !in_region)
		else $error("left startup wait without a startup message");
	startup_drop_a: assert property (
		in_region && startup_interprocessor_message |=> startup_discard)
		else $error("startup message inside region not discarded");
	reinit_reset_a: assert property (
		in_region && !core_paused && reinit_req
			&& !virt_root && !virt_nonroot
		|=> arch_reset && async_secure_exit && !in_region
			&& (run_firmware != wait_startup))
		else $error("re-init outside virtualization did not reset state");
	enter_wait_a: assert property (
		in_region && !core_paused && !reinit_req && !system_management_event
			&& launch_enter_leaf
		|=> async_secure_exit && wait_startup && !in_region)
		else $error("launch-enter inside region did not exit and wait");
	launch_ud_a: assert property (
		in_region && !core_paused && secure_launch_instruction
		|=> invalid_opcode_fault)
		else $error("secure-launch instruction inside region not faulted");
	launch_pause_a: assert property (
		core_paused && !launch_exit_done |=> core_paused)
		else $error("paused core resumed before launch-exit completed");
	exit_clears_a: assert property (
		async_secure_exit |-> !in_region)
		else $error("mode flag set during asynchronous exit");
	dma_block_a: assert property (
		dma_req && dma_hits_reserved |=> dma_reject && !dma_grant)
		else $error("reserved-memory access not rejected");
	launch_gate_a: assert property (
		module_launch_req && lock && module_version < threshold
		|=> launch_shutdown && !launch_allow)
		else $error("low-version module allowed while locked");
	flush_edge_a: assert property (
		$changed(in_region) && !$past(core_paused) && !core_paused
		|-> translation_flush && watch_clear)
		else $error("region entry or exit without flush");
endmodule // secure_region_exit_ctrl

// File: platform_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// firmware and platform event source facing the core
// ----------------------------------------------------------------
module platform_model #(
	parameter logic [7:0] FW_THR = 8'h40,
	parameter logic [7:0] FW_NEW = 8'h41
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wait_startup,
	input wire logic answer_en,
	input wire logic slow,
	input wire logic fw_update,
	output logic startup_msg,
	output logic [7:0] fw_threshold
);
	logic [3:0] cnt_r;
	logic [3:0] dly;

	// a later firmware value shows whether the latch really holds
	assign fw_threshold = fw_update ? FW_NEW : FW_THR;
	assign dly = slow ? 4'h6 : 4'h1;

	// two startup messages after the wait begins; the second one
	// lands outside the wait, as a real platform sequence would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			startup_msg <= 1'b0;
		end else begin
			startup_msg <= 1'b0;
			if (!answer_en || (!wait_startup && cnt_r == 4'h0)) begin
				cnt_r <= 4'h0;
			end else begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == dly || cnt_r == dly + 4'h2) begin
					startup_msg <= 1'b1;
				end
				if (cnt_r == dly + 4'h2) begin
					cnt_r <= 4'h0;
				end
			end
		end
	end
endmodule // platform_model

// File: testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam logic [17:0] XIT = 18'h20000, MFL = 18'h10000;
	localparam logic [17:0] ARS = 18'h08000, FWR = 18'h04000;
	localparam logic [17:0] WST = 18'h02000, VME = 18'h01000;
	localparam logic [17:0] VMB = 18'h00800, BLK = 18'h00400;
	localparam logic [17:0] DSC = 18'h00200, UDF = 18'h00100;
	localparam logic [17:0] PAU = 18'h00080, FL = 18'h00060;
	localparam logic [17:0] GNT = 18'h00010, REJ = 18'h00008;
	localparam logic [17:0] ALW = 18'h00004, SHT = 18'h00002;
	localparam logic [17:0] INR = 18'h00001, NON = 18'h00000;
	localparam logic [11:0] ENT = 12'h001, EXT = 12'h002, MGT = 12'h004;
	localparam logic [11:0] RIN = 12'h008, STU = 12'h010, SLI = 12'h020;
	localparam logic [11:0] LEN = 12'h040, LEX = 12'h080, LDN = 12'h100;
	localparam logic [11:0] IOK = 12'h200, LRQ = 12'h400, DMA = 12'h800;
	localparam logic [63:0] LOCKED = 64'h0000_0000_0040_0001;

	logic clk = 1'b0, rst = 1'b1;
	logic [11:0] ev = 12'h000;
	logic vroot = 1'b0, vnon = 1'b0, boot = 1'b0, safer = 1'b1;
	logic hits = 1'b0, status_rd = 1'b0, answer_en = 1'b0;
	logic slow = 1'b0, fw_update = 1'b0, startup_msg;
	logic [7:0] mver = 8'h00, fw_thr;
	logic [31:0] status_addr = 32'h0000_0000;
	logic [63:0] rdata;
	logic [15:0] mofs;
	logic [2:0] mbit;
	logic ack, err, inr, axit, mfl, ars, fwr, wst, vmex, vmb, blk, dsc;
	logic udf, pau, flu, wcl, gnt, rej, alw, sht;
	logic [17:0] obs;
	int fails = 0, n_checks = 0;

	always #2 clk = ~clk;
	assign obs = {axit, mfl, ars, fwr, wst, vmex, vmb, blk, dsc, udf, pau,
		flu, wcl, gnt, rej, alw, sht, inr};

	platform_model plat (.clk(clk), .rst(rst), .wait_startup(wst),
		.answer_en(answer_en), .slow(slow), .fw_update(fw_update),
		.startup_msg(startup_msg), .fw_threshold(fw_thr));

	secure_region_exit_ctrl dut (.clk(clk), .rst(rst), .enter_region(ev[0]),
		.exit_region(ev[1]), .system_management_event(ev[2]),
		.reinit_req(ev[3]),
		.startup_interprocessor_message(ev[4] | startup_msg),
		.virt_root(vroot), .virt_nonroot(vnon), .boot_core(boot),
		.secure_launch_instruction(ev[5]), .launch_enter_leaf(ev[6]),
		.launch_exit_leaf(ev[7]), .launch_exit_done(ev[8]),
		.secure_instr_ok(ev[9]), .fw_threshold(fw_thr),
		.safer_mode_support(safer), .module_launch_req(ev[10]),
		.module_version(mver), .dma_req(ev[11]), .dma_hits_reserved(hits),
		.status_rd(status_rd), .status_addr(status_addr),
		.status_rdata(rdata), .status_ack(ack), .status_err(err),
		.in_region(inr), .async_secure_exit(axit), .mgmt_flag_wr(mfl),
		.mgmt_flag_offset(mofs), .mgmt_flag_bit(mbit), .arch_reset(ars),
		.run_firmware(fwr), .wait_startup(wst), .vm_exit(vmex),
		.vm_exit_region_bit(vmb), .reinit_blocked(blk),
		.startup_discard(dsc), .invalid_opcode_fault(udf),
		.core_paused(pau), .translation_flush(flu), .watch_clear(wcl),
		.dma_grant(gnt), .dma_reject(rej), .launch_allow(alw),
		.launch_shutdown(sht));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		if (fails == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one-cycle event pulse; pulse outputs are looked at in the next cycle
	task automatic fire(input logic [11:0] m, input logic [17:0] exp,
		input string nm);
		@(posedge clk) ev <= m;
		@(posedge clk) ev <= 12'h000;
		@(negedge clk);
		chk(nm, {46'h0, obs}, {46'h0, exp});
		// hand back on a rising edge so level inputs change only there
		@(posedge clk);
	endtask

	task automatic rd(input logic [31:0] a, input logic [63:0] exp,
		input logic exp_err);
		@(posedge clk) begin
			status_rd <= 1'b1;
			status_addr <= a;
		end
		@(posedge clk) status_rd <= 1'b0;
		@(negedge clk);
		chk("status read", {ack, err, rdata}, {1'b1, exp_err, exp});
		@(posedge clk);
	endtask

	// bounded wait for the partner's startup messages to land
	task automatic wait_release;
		for (int i = 0; i < 40 && wst !== 1'b0; i++) @(negedge clk);
		repeat (4) @(negedge clk);
		chk("released", {62'h0, wst, inr}, 64'h0);
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(32'h0000_0500, 64'h0, 1'b0);
		rd(32'h0000_0501, 64'h0, 1'b1);
		fire(LRQ, ALW, "unlocked launch");
		fire(IOK, NON, "first good instr");
		fw_update <= 1'b1;
		fire(IOK, NON, "second good instr");
		fw_update <= 1'b0;
		rd(32'h0000_0500, LOCKED, 1'b0);
		safer <= 1'b0;
		rd(32'h0000_0500, 64'h1, 1'b0);
		safer <= 1'b1;
		mver <= 8'h3F;
		fire(LRQ, SHT, "low version");
		mver <= 8'h40; // newer module fetched
		fire(LRQ, ALW, "equal version");
		mver <= 8'h41;
		fire(LRQ, ALW, "higher version");
		hits <= 1'b1;
		fire(DMA, REJ, "dma reserved");
		hits <= 1'b0;
		fire(DMA, GNT, "dma plain");
		fire(ENT, INR | FL, "enter");
		fire(MGT, XIT | MFL | FL, "mgmt exit");
		chk("flag place", {45'h0, mofs, mbit}, {45'h0, 16'h7EE0, 3'h1});
		fire(ENT, INR | FL, "enter");
		fire(SLI | STU, UDF | DSC | INR, "launch inside");
		fire(EXT, FL, "plain exit");
		fire(ENT, INR | FL, "enter");
		vroot <= 1'b1;
		fire(RIN, BLK | INR, "root reinit");
		vroot <= 1'b0;
		vnon <= 1'b1;
		fire(RIN, XIT | VME | VMB | FL, "nonroot reinit");
		vnon <= 1'b0;
		boot <= 1'b1;
		fire(ENT, INR | FL, "enter");
		fire(RIN, XIT | ARS | FWR | FL, "boot reinit");
		boot <= 1'b0;
		fire(ENT, INR | FL, "enter");
		fire(RIN, XIT | ARS | WST | FL, "second reinit");
		fire(ENT, WST, "enter while waiting");
		slow <= 1'b1;
		answer_en <= 1'b1;
		wait_release;
		slow <= 1'b0;
		fire(ENT, INR | FL, "enter");
		fire(LEN, XIT | WST | FL, "launch enter");
		wait_release;
		fire(ENT, INR | FL, "enter");
		fire(LEX, PAU | INR, "launch exit");
		fire(STU, DSC | PAU | INR, "startup while paused");
		fire(LDN, INR, "launch done");
		rd(32'h0000_0500, LOCKED, 1'b0);
		tally_and_finish;
	end

	// cut a hang short; the sequence needs under two hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		tally_and_finish;
	end
endmodule // testbench
